/* rtl/serial_audio_defs.vh */
// Register map, field positions, reset values and timing for the serial audio ports
`ifndef SERIAL_AUDIO_DEFS_VH
`define SERIAL_AUDIO_DEFS_VH
`define ADDR_OUT_CTRL 4'h0
`define ADDR_OUT_CTRL2 4'h1
`define ADDR_IN_CTRL 4'h2
`define ADDR_CONV_CTRL 4'h3
`define ADDR_USER_CTRL1 4'h4
`define RST_OUT_CTRL 16'h0000
`define RST_OUT_CTRL2 16'h0000
`define RST_IN_CTRL 16'h0000
`define RST_CONV_CTRL 16'h0000
`define RST_USER_CTRL1 16'h0000
`define RST_LFSR 16'hACE1
`define OC_DITHER 15
`define OC_TDM16 14
`define OC_FPOL 13
`define OC_BPOL 12
`define OC_MASTER 11
`define OC_BDIV_HI 10
`define OC_BDIV_LO 9
`define OC_FLEN_HI 8
`define OC_FLEN_LO 7
`define OC_PULSE 6
`define OC_TDM_EN 5
`define OC_MSB_HI 4
`define OC_MSB_LO 2
`define OC_WLEN_HI 1
`define OC_WLEN_LO 0
`define IC_TDM16 5
`define IC_FPOL 4
`define IC_BPOL 3
`define IC_MODE_HI 2
`define IC_MODE_LO 0
`define CC_SEL_HI 6
`define CC_SEL_LO 5
`define CC_FPOL 4
`define CC_BPOL 3
`define CC_MODE_HI 2
`define CC_MODE_LO 0
`define UC_MUX_EN 8
`define UC_LOCK 7
`define UC_STORE_HI 6
`define UC_FIXED_ONES 4'hF
`define MODE_I2S 3'h0
`define MODE_LJ 3'h1
`define MODE_RJ24 3'h2
`define MODE_TDM 3'h4
`define DELAY_I2S 5'h01
`define DELAY_RJ24 5'h08
`define DELAY_NONE 5'h00
`define WLEN_SEL0 5'h18
`define WLEN_SEL1 5'h14
`define WLEN_SEL2 5'h10
`define WLEN_SEL3 5'h08
`define WORD_BITS 5'h18
`define WORD_LAST 5'h17
`define SLOT_LAST 5'h1F
`define FRAME_MIN 10'h040
`define TDM8_SLOTS 5'h08
`define TDM16_SLOTS 5'h10
`define STEREO_SLOTS 5'h02
`define CLK_HZ 10000000
`define LOCK_TIMEOUT_US 1000
`define LOCK_TIMEOUT_CYC (`LOCK_TIMEOUT_US * (`CLK_HZ / 1000000))
`endif

/* rtl/serial_audio_port_config.v */
// Serial audio output and input ports, converter input port, FIFO and control registers
`timescale 1ns/1ns
`include "serial_audio_defs.vh"

////////////////////////////////////////////////////////////////////////////////
module sample_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire clk_in,
  input wire reset_n_in,
  // Fill side
  input wire [WIDTH-1:0] in_data_in,
  input wire in_valid_in,
  output wire in_ready_out,
  // Drain side
  output wire [WIDTH-1:0] out_data_out,
  output wire out_valid_out,
  input wire out_ready_in
);
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0] wr_ff;
  reg [AW-1:0] rd_ff;
  reg [AW:0] count_ff;
  reg ready_ff;
  wire push = in_valid_in & ready_ff;
  wire pop = out_ready_in & (count_ff != {(AW+1){1'b0}});
  wire [AW:0] nxt_count = count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign in_ready_out = ready_ff;
  assign out_valid_out = (count_ff != {(AW+1){1'b0}});
  assign out_data_out = mem_ff[rd_ff];
  // Storage needs no reset; pointers wrap naturally, so DEPTH is a power of two
  always @(posedge clk_in) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data_in;
    end
  end
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ff <= {AW{1'b0}};
      rd_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
      ready_ff <= 1'b0;
    end else begin
      if (push) begin
        wr_ff <= wr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ff <= rd_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      count_ff <= nxt_count;
      ready_ff <= (nxt_count < DEPTH);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module frame_capture #(
  parameter LANES = 4
) (
  // Clock and reset
  input wire clk_in,
  input wire reset_n_in,
  // Cleaned link levels
  input wire bclk_in,
  input wire fclk_in,
  input wire [LANES-1:0] data_in,
  // Format
  input wire [LANES-1:0] mask_in,
  input wire bpol_in,
  input wire fpol_in,
  input wire tdm_in,
  input wire tdm16_in,
  input wire [4:0] delay_in,
  // Captured words
  output reg [LANES*24-1:0] words_out,
  output reg [3:0] slot_out,
  output reg valid_out
);
  reg bprev_ff;
  reg flast_ff;
  reg chan_ff;
  reg [9:0] cnt_ff;
  reg [LANES*24-1:0] shift_ff;
  reg [LANES*24-1:0] nxt_shift;
  reg [9:0] nxt_cnt;
  reg restart;
  integer l;
  integer j;
  // Capture on the edge opposite to the one where data changes
  wire cap = (bclk_in != bprev_ff) && (bclk_in != bpol_in);
  wire [5:0] first = {1'b0, delay_in};
  wire [5:0] last = first + {1'b0, `WORD_LAST};
  wire [5:0] pos = {1'b0, nxt_cnt[4:0]};
  wire [4:0] nslots = tdm16_in ? `TDM16_SLOTS : `TDM8_SLOTS;
  wire slot_ok = tdm_in ? (nxt_cnt[9:5] < nslots) : (nxt_cnt[9:5] == 5'h00);
  always @* begin
    // TDM frames restart only on the edge into the polarity level, stereo frames on either edge
    restart = (fclk_in != flast_ff) && (!tdm_in || (fclk_in == fpol_in));
    nxt_cnt = restart ? 10'h000 : (cnt_ff + 10'h001);
    nxt_shift = shift_ff;
    if (pos >= first && pos <= last) begin
      for (l = 0; l < LANES; l = l + 1) begin
        nxt_shift[l*24 +: 24] = {shift_ff[l*24 +: 23], data_in[l]};
      end
    end
  end
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bprev_ff <= 1'b0;
      flast_ff <= 1'b0;
      chan_ff <= 1'b0;
      cnt_ff <= 10'h000;
      shift_ff <= {(LANES*24){1'b0}};
      words_out <= {(LANES*24){1'b0}};
      slot_out <= 4'h0;
      valid_out <= 1'b0;
    end else begin
      bprev_ff <= bclk_in;
      valid_out <= 1'b0;
      if (cap) begin
        flast_ff <= fclk_in;
        cnt_ff <= nxt_cnt;
        shift_ff <= nxt_shift;
        if (restart && !tdm_in) begin
          chan_ff <= fclk_in ^ fpol_in;
        end
        if (pos == last && slot_ok && !(&mask_in)) begin
          valid_out <= 1'b1;
          slot_out <= tdm_in ? nxt_cnt[8:5] : {3'h0, (restart ? (fclk_in ^ fpol_in) : chan_ff)};
          for (j = 0; j < LANES; j = j + 1) begin
            words_out[j*24 +: 24] <= mask_in[j] ? 24'h000000 : nxt_shift[j*24 +: 24];
          end
        end
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module serial_audio_port_config #(
  parameter LOCK_CYCLES = `LOCK_TIMEOUT_CYC,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  // Clock and reset
  input wire clk_in,
  input wire reset_n_in,
  // Control port
  input wire [3:0] reg_addr_in,
  input wire [15:0] reg_wdata_in,
  input wire reg_wr_in,
  output reg [15:0] reg_rdata_out,
  // Output samples from the core
  input wire [23:0] tx_data_in,
  input wire tx_valid_in,
  output wire tx_ready_out,
  // Main port pins
  input wire main_bit_clock_in,
  output wire main_bit_clock_out,
  output wire main_bit_clock_oe_out,
  input wire main_frame_clock_in,
  output wire main_frame_clock_out,
  output wire main_frame_clock_oe_out,
  output wire first_serial_data_out,
  input wire [3:0] serial_data_inputs_in,
  // Converter port pins
  input wire src_bit_clock_in,
  input wire src_frame_clock_in,
  // Direct input words to the core
  output wire [95:0] rx_words_out,
  output wire [3:0] rx_slot_out,
  output wire rx_valid_out,
  // Converter input words
  output wire [23:0] src_word_out,
  output wire src_right_out,
  output wire src_valid_out
);
  reg [15:0] oc_ff;
  reg [15:0] oc2_ff;
  reg [15:0] ic_ff;
  reg [15:0] cc_ff;
  reg [15:0] uc_ff;
  reg [7:0] sync1_ff;
  reg [7:0] sync2_ff;
  reg [7:0] sync3_ff;
  reg [7:0] clean_ff;
  reg [15:0] lfsr_ff;
  reg [3:0] div_ff;
  reg gen_bclk_ff;
  reg gen_fclk_ff;
  reg [9:0] gen_cnt_ff;
  reg mb_prev_ff;
  reg of_last_ff;
  reg [9:0] ocnt_ff;
  reg [3:0] oslot_ff;
  reg [23:0] oword_ff;
  reg sdo_ff;
  reg lock_ff;
  reg [19:0] lock_cnt_ff;
  reg [9:0] nxt_ocnt;
  reg [3:0] nxt_oslot;
  reg [23:0] nxt_oword;
  reg [24:0] dsum;
  reg newslot;
  reg pop;
  wire [23:0] fifo_data;
  wire fifo_valid;
  wire [3:0] rx_slot;
  wire [0:0] src_right;
  // Upper slot bits mean nothing on the stereo-only lane
  wire [2:0] src_dummy_hi;

  function [4:0] word_len;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: word_len = `WLEN_SEL0;
        2'h1: word_len = `WLEN_SEL1;
        2'h2: word_len = `WLEN_SEL2;
        default: word_len = `WLEN_SEL3;
      endcase
    end
  endfunction

  // Polarity and edge bits are separate inputs, so they win over the mode field
  function [4:0] in_delay;
    input [2:0] mode;
    begin
      case (mode)
        `MODE_I2S: in_delay = `DELAY_I2S;
        `MODE_RJ24: in_delay = `DELAY_RJ24;
        default: in_delay = `DELAY_NONE;
      endcase
    end
  endfunction

  function out_bit;
    input [23:0] word;
    input [4:0] bitpos;
    input [2:0] msb;
    input [4:0] len;
    reg [4:0] p;
    begin
      p = bitpos - {2'h0, msb};
      out_bit = (bitpos >= {2'h0, msb} && p < len) ? word[`WORD_LAST - p] : 1'b0;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  wire [15:0] uc_read = {3'h0, `UC_FIXED_ONES, uc_ff[`UC_MUX_EN], lock_ff,
    uc_ff[`UC_STORE_HI:0]};
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      oc_ff <= `RST_OUT_CTRL;
      oc2_ff <= `RST_OUT_CTRL2;
      ic_ff <= `RST_IN_CTRL;
      cc_ff <= `RST_CONV_CTRL;
      uc_ff <= `RST_USER_CTRL1;
      reg_rdata_out <= 16'h0000;
    end else begin
      if (reg_wr_in) begin
        case (reg_addr_in)
          `ADDR_OUT_CTRL: oc_ff <= reg_wdata_in;
          `ADDR_OUT_CTRL2: oc2_ff <= reg_wdata_in;
          `ADDR_IN_CTRL: ic_ff <= reg_wdata_in;
          `ADDR_CONV_CTRL: cc_ff <= reg_wdata_in;
          `ADDR_USER_CTRL1: uc_ff <= reg_wdata_in;
          default: ;
        endcase
      end
      case (reg_addr_in)
        `ADDR_OUT_CTRL: reg_rdata_out <= oc_ff;
        `ADDR_OUT_CTRL2: reg_rdata_out <= oc2_ff;
        `ADDR_IN_CTRL: reg_rdata_out <= ic_ff;
        `ADDR_CONV_CTRL: reg_rdata_out <= cc_ff;
        `ADDR_USER_CTRL1: reg_rdata_out <= uc_read;
        default: reg_rdata_out <= 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a change counts once stages two and three agree
  wire [7:0] pin_vec = {serial_data_inputs_in, main_bit_clock_in, main_frame_clock_in,
    src_bit_clock_in, src_frame_clock_in};
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1_ff <= 8'h00;
      sync2_ff <= 8'h00;
      sync3_ff <= 8'h00;
      clean_ff <= 8'h00;
      lfsr_ff <= `RST_LFSR;
    end else begin
      sync1_ff <= pin_vec;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      clean_ff <= ((sync2_ff ~^ sync3_ff) & sync3_ff) | ((sync2_ff ^ sync3_ff) & clean_ff);
      lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Master clock generator
  wire master = oc_ff[`OC_MASTER];
  wire obpol = oc_ff[`OC_BPOL];
  wire ofpol = oc_ff[`OC_FPOL];
  wire pulse = oc_ff[`OC_PULSE];
  wire [3:0] half_div = 4'h1 << oc_ff[`OC_BDIV_HI:`OC_BDIV_LO];
  wire [9:0] flen = `FRAME_MIN << oc_ff[`OC_FLEN_HI:`OC_FLEN_LO];
  wire [9:0] gen_nxt = (gen_cnt_ff == flen - 10'h001) ? 10'h000 : (gen_cnt_ff + 10'h001);
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div_ff <= 4'h0;
      gen_bclk_ff <= 1'b0;
      gen_fclk_ff <= 1'b0;
      gen_cnt_ff <= 10'h000;
    end else if (div_ff == half_div - 4'h1) begin
      div_ff <= 4'h0;
      gen_bclk_ff <= ~gen_bclk_ff;
      // Frame clock moves with the data, on the change edge
      if (~gen_bclk_ff == obpol) begin
        gen_cnt_ff <= gen_nxt;
        if (pulse) begin
          gen_fclk_ff <= (gen_nxt == 10'h000) ? ofpol : ~ofpol;
        end else begin
          gen_fclk_ff <= (gen_nxt >= (flen >> 1)) ^ ofpol;
        end
      end
    end else begin
      div_ff <= div_ff + 4'h1;
    end
  end
  assign main_bit_clock_out = gen_bclk_ff;
  assign main_frame_clock_out = gen_fclk_ff;
  assign main_bit_clock_oe_out = oc_ff[`OC_MASTER];
  assign main_frame_clock_oe_out = oc_ff[`OC_MASTER];

  ////////////////////////////////////////////////////////////////////////////////
  // Output serializer
  wire mb = master ? gen_bclk_ff : clean_ff[3];
  wire mf = master ? gen_fclk_ff : clean_ff[2];
  wire och = (mb != mb_prev_ff) && (mb == obpol);
  wire tdm_out = oc_ff[`OC_TDM_EN];
  wire tdm16 = oc_ff[`OC_TDM16] & oc_ff[`OC_TDM_EN] & oc2_ff[`OC_TDM_EN];
  wire [4:0] nch = tdm_out ? (tdm16 ? `TDM16_SLOTS : `TDM8_SLOTS) : `STEREO_SLOTS;
  wire [4:0] olen = word_len(oc_ff[`OC_WLEN_HI:`OC_WLEN_LO]);
  wire ostart = (mf != of_last_ff) && (!(tdm_out | pulse) || (mf == ofpol));
  always @* begin
    nxt_ocnt = ocnt_ff;
    nxt_oslot = oslot_ff;
    nxt_oword = oword_ff;
    newslot = 1'b0;
    pop = 1'b0;
    dsum = {1'b0, fifo_data} + ({24'h000000, lfsr_ff[0]} << (`WORD_BITS - olen));
    if (och) begin
      if (ostart) begin
        nxt_ocnt = 10'h000;
        nxt_oslot = (tdm_out | pulse) ? 4'h0 : {3'h0, mf ^ ofpol};
        newslot = 1'b1;
      end else begin
        nxt_ocnt = ocnt_ff + 10'h001;
        if (ocnt_ff[4:0] == `SLOT_LAST) begin
          nxt_oslot = ({1'b0, oslot_ff} == nch - 5'h01) ? 4'h0 : (oslot_ff + 4'h1);
          newslot = 1'b1;
        end
      end
      if (newslot) begin
        pop = fifo_valid;
        // Dither is skipped rather than wrapping a full-scale word
        if (!fifo_valid) begin
          nxt_oword = 24'h000000;
        end else if (oc_ff[`OC_DITHER] && !dsum[24]) begin
          nxt_oword = dsum[23:0];
        end else begin
          nxt_oword = fifo_data;
        end
      end
    end
  end
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mb_prev_ff <= 1'b0;
      of_last_ff <= 1'b0;
      ocnt_ff <= 10'h000;
      oslot_ff <= 4'h0;
      oword_ff <= 24'h000000;
      sdo_ff <= 1'b0;
    end else begin
      mb_prev_ff <= mb;
      if (och) begin
        of_last_ff <= mf;
        ocnt_ff <= nxt_ocnt;
        oslot_ff <= nxt_oslot;
        oword_ff <= nxt_oword;
        sdo_ff <= out_bit(nxt_oword, nxt_ocnt[4:0], oc_ff[`OC_MSB_HI:`OC_MSB_LO], olen);
      end
    end
  end
  assign first_serial_data_out = sdo_ff;

  sample_fifo #(.WIDTH(24), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) tx_fifo (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .in_data_in(tx_data_in),
    .in_valid_in(tx_valid_in),
    .in_ready_out(tx_ready_out),
    .out_data_out(fifo_data),
    .out_valid_out(fifo_valid),
    .out_ready_in(pop)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Input ports
  wire mux_en = uc_ff[`UC_MUX_EN];
  wire [1:0] sel = cc_ff[`CC_SEL_HI:`CC_SEL_LO];
  wire [3:0] direct_mask = mux_en ? (4'h1 << sel) : 4'h0;
  wire in_tdm = (ic_ff[`IC_MODE_HI:`IC_MODE_LO] == `MODE_TDM);

  frame_capture #(.LANES(4)) main_capture (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .bclk_in(mb),
    .fclk_in(mf),
    .data_in(clean_ff[7:4]),
    .mask_in(direct_mask),
    .bpol_in(ic_ff[`IC_BPOL]),
    .fpol_in(ic_ff[`IC_FPOL]),
    .tdm_in(in_tdm),
    .tdm16_in(ic_ff[`IC_TDM16]),
    .delay_in(in_delay(ic_ff[`IC_MODE_HI:`IC_MODE_LO])),
    .words_out(rx_words_out),
    .slot_out(rx_slot),
    .valid_out(rx_valid_out)
  );
  assign rx_slot_out = rx_slot;

  // Converter lane is stereo only, so TDM inputs are tied off
  frame_capture #(.LANES(1)) src_capture (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .bclk_in(clean_ff[1]),
    .fclk_in(clean_ff[0]),
    .data_in(clean_ff[3'h4 + {1'b0, sel}]),
    .mask_in(~mux_en),
    .bpol_in(cc_ff[`CC_BPOL]),
    .fpol_in(cc_ff[`CC_FPOL]),
    .tdm_in(1'b0),
    .tdm16_in(1'b0),
    .delay_in(in_delay(cc_ff[`CC_MODE_HI:`CC_MODE_LO])),
    .words_out(src_word_out),
    .slot_out({src_dummy_hi, src_right}),
    .valid_out(src_valid_out)
  );
  assign src_right_out = src_right[0];

  // Lock shows converter words arriving recently
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lock_ff <= 1'b0;
      lock_cnt_ff <= 20'h00000;
    end else if (src_valid_out) begin
      lock_ff <= 1'b1;
      lock_cnt_ff <= 20'h00000;
    end else if (lock_ff) begin
      lock_cnt_ff <= lock_cnt_ff + 20'h00001;
      if (lock_cnt_ff == LOCK_CYCLES - 1) begin
        lock_ff <= 1'b0;
      end
    end
  end
endmodule

/* tb/serial_audio_port_sva.sv */
// Checker for the serial audio port block, watching its top-level ports
`timescale 1ns/1ns
module serial_audio_port_sva (
  // Clock and reset
  input wire clk_in,
  input wire reset_n_in,
  // Control port
  input wire [3:0] reg_addr_in,
  input wire [15:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire [15:0] reg_rdata_out,
  // Pins and words
  input wire main_bit_clock_out,
  input wire main_bit_clock_oe_out,
  input wire main_frame_clock_out,
  input wire main_frame_clock_oe_out,
  input wire first_serial_data_out,
  input wire [95:0] rx_words_out,
  input wire rx_valid_out,
  input wire src_valid_out
);
  reg [15:0] oc_ff;
  reg [15:0] cc_ff;
  reg [15:0] uc_ff;
  reg [7:0] age_ff;
  reg [7:0] run_ff;
  reg last_ff;
  default clocking dc @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  ////////////////////////////////////////////////////////////////////////////////
  // Shadows; age guards checks against a fresh reconfiguration
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      oc_ff <= 16'h0000;
      cc_ff <= 16'h0000;
      uc_ff <= 16'h0000;
      age_ff <= 8'h00;
      run_ff <= 8'h00;
      last_ff <= 1'b0;
    end else begin
      if (reg_wr_in && reg_addr_in == 4'h0) oc_ff <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == 4'h3) cc_ff <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == 4'h4) uc_ff <= reg_wdata_in;
      age_ff <= reg_wr_in ? 8'h00 : ((age_ff == 8'hFF) ? age_ff : age_ff + 8'h01);
      last_ff <= main_bit_clock_out;
      run_ff <= (main_bit_clock_out != last_ff) ? 8'h00 : run_ff + 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  oe_track_a: assert property (age_ff > 8'h01 |-> main_bit_clock_oe_out == oc_ff[11]
    && main_frame_clock_oe_out == oc_ff[11]) else $error("clock enables wrong");
  bclk_rate_a: assert property (age_ff == 8'hFF && main_bit_clock_oe_out
    && main_bit_clock_out != last_ff |-> run_ff == (8'h01 << oc_ff[10:9]) - 8'h01)
    else $error("bit clock half period wrong");
  // Data register follows the bit clock's falling edge one cycle later
  data_edge_a: assert property (age_ff == 8'hFF && main_bit_clock_oe_out && !oc_ff[12]
    && $changed(first_serial_data_out) |-> !$past(main_bit_clock_out)
    && $past(main_bit_clock_out, 2)) else $error("data changed off the falling edge");
  frame_edge_a: assert property (age_ff == 8'hFF && main_frame_clock_oe_out && !oc_ff[12]
    && $changed(main_frame_clock_out) |-> $fell(main_bit_clock_out))
    else $error("frame clock changed off the change edge");
  src_gate_a: assert property (src_valid_out |-> uc_ff[8] || $past(uc_ff[8]))
    else $error("converter word while mux disabled");
  lane_mask_a: assert property (age_ff == 8'hFF && rx_valid_out && uc_ff[8]
    |-> rx_words_out[cc_ff[6:5]*24 +: 24] == 24'h000000) else $error("lane not masked");
  unmapped_a: assert property (reg_addr_in > 4'h4 |=> reg_rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  user_fixed_a: assert property (reg_addr_in == 4'h4 |=> reg_rdata_out[15:9] == 7'h0F
    && reg_rdata_out[8] == $past(uc_ff[8])) else $error("user control readback wrong");
  reg_rw_a: assert property (reg_addr_in == 4'h0 |=> reg_rdata_out == $past(oc_ff))
    else $error("output control readback wrong");
endmodule

bind serial_audio_port_config serial_audio_port_sva chk (.clk_in(clk_in),
  .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rdata_out(reg_rdata_out),
  .main_bit_clock_out(main_bit_clock_out), .main_bit_clock_oe_out(main_bit_clock_oe_out),
  .main_frame_clock_out(main_frame_clock_out),
  .main_frame_clock_oe_out(main_frame_clock_oe_out),
  .first_serial_data_out(first_serial_data_out), .rx_words_out(rx_words_out),
  .rx_valid_out(rx_valid_out), .src_valid_out(src_valid_out));

/* tb/far_end_model.sv */
// Far-end audio source: drives bit clock, frame clock and four data lanes
`timescale 1ns/1ns
module far_end_model (
  // Link pins
  output reg bclk_out = 1'b1,
  output reg fclk_out = 1'b1,
  output reg [3:0] lanes_out = 4'hA
);
  integer i;
  integer k;
  ////////////////////////////////////////////////////////////////////////////////
  // One stereo frame of 64 bits; clock stands still between frames
  task send_frame(input [95:0] lw, input [95:0] rw, input integer dly);
    reg [95:0] w;
    integer p;
    begin
      for (i = 0; i < 64; i = i + 1) begin
        bclk_out = 1'b0;
        fclk_out = (i >= 32);
        w = (i < 32) ? lw : rw;
        p = (i % 32) - dly;
        // Bits outside the word toggle so stale values cannot pass
        for (k = 0; k < 4; k = k + 1)
          lanes_out[k] = (p >= 0 && p < 24) ? w[k*24 + 23 - p] : ~lanes_out[k];
        #400 bclk_out = 1'b1;
        #400;
      end
      lanes_out = ~lanes_out;
    end
  endtask
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the serial audio port block
`timescale 1ns/1ns
module tb_top;
  reg clk_in = 1'b0;
  reg reset_n_in = 1'b0;
  reg [3:0] reg_addr_in = 4'h0;
  reg [15:0] reg_wdata_in = 16'h0000;
  reg reg_wr_in = 1'b0;
  reg [23:0] tx_data_in = 24'hC35A96;
  reg tx_valid_in = 1'b0;
  wire [15:0] reg_rdata_out;
  wire tx_ready_out, bclk_out, bclk_oe, fclk_out, fclk_oe, sdo, far_bclk, far_fclk;
  wire rx_valid_out, src_right_out, src_valid_out;
  wire [3:0] lanes;
  wire [3:0] rx_slot_out;
  wire [95:0] rx_words_out;
  wire [23:0] src_word_out;
  wire bclk_pin = bclk_oe ? bclk_out : far_bclk;
  wire fclk_pin = fclk_oe ? fclk_out : far_fclk;
  localparam [95:0] lw_pat = 96'h123456_89ABCD_F0E1D2_5A3C96;
  integer n_fail = 0;
  integer total_checks = 0;
  integer cycles = 0;
  integer i, m, n, p, pb, flen, dly;
  time t_last = 0;
  time bper = 0;
  reg last_f = 1'b0;
  reg [1:0] sel;
  reg [31:0] mbits;
  reg [95:0] got_rx [0:1];
  reg [23:0] got_src [0:1];

  serial_audio_port_config #(.LOCK_CYCLES(50)) dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rdata_out(reg_rdata_out), .tx_data_in(tx_data_in), .tx_valid_in(tx_valid_in),
    .tx_ready_out(tx_ready_out), .main_bit_clock_in(bclk_pin),
    .main_bit_clock_out(bclk_out), .main_bit_clock_oe_out(bclk_oe),
    .main_frame_clock_in(fclk_pin), .main_frame_clock_out(fclk_out),
    .main_frame_clock_oe_out(fclk_oe), .first_serial_data_out(sdo),
    .serial_data_inputs_in(lanes), .src_bit_clock_in(far_bclk), .src_frame_clock_in(far_fclk),
    .rx_words_out(rx_words_out), .rx_slot_out(rx_slot_out), .rx_valid_out(rx_valid_out),
    .src_word_out(src_word_out), .src_right_out(src_right_out), .src_valid_out(src_valid_out));
  far_end_model far (.bclk_out(far_bclk), .fclk_out(far_fclk), .lanes_out(lanes));

  always #50 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input ok, input string msg);
    begin
      total_checks = total_checks + 1;
      if (!ok) begin
        n_fail = n_fail + 1;
        $display("MISMATCH at %0t: %0s", $time, msg);
      end
    end
  endtask
  task wr(input [3:0] a, input [15:0] d);
    begin
      @(negedge clk_in);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = 1'b1;
      @(negedge clk_in);
      reg_wr_in = 1'b0;
    end
  endtask
  task rd_chk(input [3:0] a, input [15:0] exp);
    begin
      @(negedge clk_in);
      reg_addr_in = a;
      repeat (2) @(negedge clk_in);
      chk(reg_rdata_out === exp, "register readback");
    end
  endtask
  task summarize;
    begin
      $display("Checks: %0d, mismatches: %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Monitors: captured words, and the master output frame seen by a listener
  always @(posedge clk_in) begin
    cycles = cycles + 1;
    if (rx_valid_out === 1'b1) got_rx[rx_slot_out[0]] <= rx_words_out;
    if (src_valid_out === 1'b1) got_src[src_right_out] <= src_word_out;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      $display("MISMATCH at %0t: run timed out", $time);
      summarize;
    end
  end
  always @(posedge bclk_out) begin
    if (fclk_out !== last_f) p = 0;
    else p = p + 1;
    if (fclk_out === 1'b0 && last_f === 1'b1) begin
      flen = pb;
      pb = 0;
    end
    pb = pb + 1;
    bper = $time - t_last;
    t_last = $time;
    last_f = fclk_out;
    if (fclk_out === 1'b0 && p < 32) mbits[31-p] = sdo;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(negedge clk_in);
    reset_n_in = 1'b1;
    for (i = 0; i < 4; i = i + 1) rd_chk(i[3:0], 16'h0000);
    rd_chk(4'h4, 16'h1E00);
    for (i = 0; i < 4; i = i + 1) begin
      wr(i[3:0], 16'hA5C3);
      rd_chk(i[3:0], 16'hA5C3);
      wr(i[3:0], 16'h0000);
    end
    wr(4'h4, 16'hFFFF);
    rd_chk(4'h4, 16'h1F7F);
    wr(4'h9, 16'hFFFF);
    rd_chk(4'h9, 16'h0000);
    rd_chk(4'h2, 16'h0000);
    // I2S, left-justified and right-justified input through both ports
    for (m = 0; m < 3; m = m + 1) begin
      sel = m + 1;
      dly = (m == 0) ? 1 : ((m == 2) ? 8 : 0);
      wr(4'h2, m[15:0]);
      wr(4'h3, {9'h000, sel, 2'b00, m[2:0]});
      wr(4'h4, 16'h0100);
      got_rx[0] = 0; got_rx[1] = 0; got_src[0] = 0; got_src[1] = 0;
      far.send_frame(lw_pat, ~lw_pat, dly);
      repeat (20) @(negedge clk_in);
      chk(got_rx[0] === (lw_pat & ~(96'hFFFFFF << (24 * sel))), "left words");
      chk(got_rx[1] === (~lw_pat & ~(96'hFFFFFF << (24 * sel))), "right words");
      chk(got_src[0] === lw_pat[sel*24 +: 24], "converter left");
      chk(got_src[1] === ~lw_pat[sel*24 +: 24], "converter right");
    end
    // Fill the FIFO while no bit clock drains it
    n = 0;
    @(negedge clk_in);
    tx_valid_in = 1'b1;
    for (i = 0; i < 40; i = i + 1) begin
      if (tx_ready_out === 1'b1) n = n + 1;
      @(negedge clk_in);
    end
    // Valid stays high so master slots never run dry
    chk(n == 16, "FIFO depth");
    // Master mode at two clock rates and frame lengths
    for (m = 0; m < 2; m = m + 1) begin
      wr(4'h0, 16'h0806 | ((m + 1) << 9) | (m << 7));
      repeat (800 + m * 1500) @(negedge clk_in);
      chk(bclk_oe === 1'b1 && fclk_oe === 1'b1, "clock enables");
      chk(bper == (400 << m), "bit clock period");
      chk(flen == (64 << m), "frame length");
      chk(mbits[30:0] === {tx_data_in[23:8], 15'h0000}, "output word");
    end
    summarize;
  end
endmodule
